// ---- mcdma_arb.sv ----
// Fixed two-level channel picker for the DMA controller.
// Purely combinational; the caller registers whatever it takes from it.
`timescale 1ns/1ps

module mcdma_arb
(
  input  wire logic [3:0] pend,
  input  wire logic [3:0] hi,
  output logic            any,
  output logic [1:0]      gnt
);

  logic [3:0] pick;

  always_comb
  begin
    pick = ((pend & hi) != 4'h0) ? (pend & hi) : pend;
    any  = (pend != 4'h0);
    gnt  = 2'h0;
    // Scan downward so the lowest set channel is left last
    for (int i = 3; i >= 0; i--)
    begin
      if (pick[i])
      begin
        gnt = 2'(i);
      end
    end
  end

endmodule

// ---- mcdma_mem_model.sv ----
// Behavioural RAM standing on the memory port of the DMA controller.
// Assumes one request per cycle, read data only in the cycle after a read.
`timescale 1ns/1ps

module mcdma_mem_model
(
  input  wire logic                  clk,
  input  wire mcdma_pkg::mcdma_mem_t mem_in,
  output logic [31:0]                rdata
);
  logic [31:0] ram [0:1023];
  logic [31:0] w;
  logic [4:0]  sh;

  initial rdata = 32'hA5A5_5A5A;

  // ==========================================================
  // Port
  always @(posedge clk)
  begin
    w  = ram[mem_in.addr[11:2]];
    sh = {mem_in.addr[1:0], 3'h0};
    if (mem_in.req && mem_in.we)
    begin
      // Lanes follow the address; element arrives in low bits
      case (mem_in.size)
        2'h0: w[sh +: 8] = mem_in.wdata[7:0];
        2'h1: w[sh +: 16] = mem_in.wdata[15:0];
        default: w = mem_in.wdata;
      endcase
      ram[mem_in.addr[11:2]] <= w;
    end
    // Stale data flips so a late sample never looks right
    rdata <= (mem_in.req && !mem_in.we) ? w >> sh : ~rdata;
  end
endmodule

// ---- mcdma_params.svh ----
// Constants of the four-channel DMA controller: register offsets,
// control-word fields, mode and code values, descriptor layout.
// Included by the top module and the bench; holds definitions and nothing else.
`ifndef MCDMA_PARAMS_SVH
`define MCDMA_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define MCDMA_OFS_CFG      8'h00
`define MCDMA_OFS_BASE     8'h04
`define MCDMA_OFS_ALT      8'h08
`define MCDMA_OFS_SWREQ    8'h0C
`define MCDMA_OFS_PRSET    8'h10
`define MCDMA_OFS_PRCLR    8'h14
`define MCDMA_OFS_RMSET    8'h18
`define MCDMA_OFS_RMCLR    8'h1C
`define MCDMA_OFS_ENSET    8'h20
`define MCDMA_OFS_ENCLR    8'h24
`define MCDMA_OFS_PASET    8'h28
`define MCDMA_OFS_PACLR    8'h2C
`define MCDMA_OFS_DONE     8'h30
`define MCDMA_OFS_ERR      8'h34
`define MCDMA_OFS_DIESET   8'h38
`define MCDMA_OFS_DIECLR   8'h3C
`define MCDMA_OFS_EIESET   8'h40
`define MCDMA_OFS_EIECLR   8'h44

// ==========================================================
// Descriptor layout
`define MCDMA_ALT_OFS      32'h00000040
`define MCDMA_BASE_ZERO    7'h00
`define MCDMA_IDX_SRC      2'h0
`define MCDMA_IDX_DST      2'h1
`define MCDMA_IDX_CTL      2'h2

// ==========================================================
// Control word fields
`define MCDMA_DINC_MSB     31
`define MCDMA_DINC_LSB     30
`define MCDMA_DSIZE_MSB    29
`define MCDMA_DSIZE_LSB    28
`define MCDMA_SINC_MSB     27
`define MCDMA_SINC_LSB     26
`define MCDMA_SSIZE_MSB    25
`define MCDMA_SSIZE_LSB    24
`define MCDMA_R_MSB        17
`define MCDMA_R_LSB        14
`define MCDMA_CNT_MSB      13
`define MCDMA_CNT_LSB      4
`define MCDMA_MODE_MSB     2
`define MCDMA_MODE_LSB     0

// ==========================================================
// Codes
`define MCDMA_INC_NONE     2'h3
`define MCDMA_SIZE_RSVD    2'h3
`define MCDMA_SIZE_WORD    2'h2
`define MCDMA_M_STOP       3'h0
`define MCDMA_M_BASIC      3'h1
`define MCDMA_M_AUTO       3'h2
`define MCDMA_M_PING       3'h3
`define MCDMA_M_MSG_PRI    3'h4
`define MCDMA_M_MSG_ALT    3'h5
`define MCDMA_M_PSG_PRI    3'h6
`define MCDMA_M_PSG_ALT    3'h7

`endif

// ---- mcdma_pkg.sv ----
// Types of the four-channel DMA controller.
// Constants live in mcdma_params.svh; this package holds only types.
package mcdma_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_FW, S_FCAP, S_RD, S_RW, S_RCAP, S_WR, S_WB
  } mcdma_state_t;

  // Memory request: read data return in the cycle after req
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mcdma_mem_t;

  typedef struct packed {
    mcdma_state_t state;
    logic [1:0]   ch;
    logic         use_alt;
    logic [1:0]   idx;
    logic [2:0]   mode;
    logic         fin;
    logic [10:0]  burst;
    logic [31:0]  src;
    logic [31:0]  dst;
    logic [31:0]  ctl;
    logic [31:0]  data;
    logic         mst_en;
    logic [31:0]  base;
    logic [3:0]   swreq;
    logic [3:0]   auto;
    logic [3:0]   prio;
    logic [3:0]   mask;
    logic [3:0]   en;
    logic [3:0]   alt;
    logic [3:0]   done;
    logic [3:0]   err;
    logic [3:0]   done_ie;
    logic [3:0]   err_ie;
    logic [31:0]  rdata;
    logic         irq;
    logic [3:0]   hw_ack;
    mcdma_mem_t   mem;
  } mcdma_st_t;

endpackage

// ---- mcdma_top.sv ----
// Four-channel DMA controller: register file, arbitration, descriptor
// fetch, element moves and descriptor write-back.
// Assumes a memory that takes one request per cycle and returns read
// data in the cycle after the request, with no stall.
`timescale 1ns/1ps
`include "mcdma_params.svh"

module mcdma_top
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic [3:0]        hw_req,
  output logic [3:0]             hw_ack,
  output mcdma_pkg::mcdma_mem_t  mem_out,
  input  wire logic [31:0]       mem_rdata,
  output logic                   dma_irq
);

  mcdma_pkg::mcdma_st_t st;
  mcdma_pkg::mcdma_st_t n;
  logic [3:0]           pend;
  logic                 any;
  logic [1:0]           gnt;

  // Step code doubles as a shift amount; no-step keeps the end address
  function automatic logic [31:0] elem_addr(input logic [31:0] ep,
                                            input logic [9:0]  cnt,
                                            input logic [1:0]  inc);
    if (inc == `MCDMA_INC_NONE)
    begin
      return ep;
    end
    return ep - ({22'h0, cnt} << inc);
  endfunction

  // ==========================================================
  // Arbitration
  always_comb
  begin
    pend = 4'h0;
    if (st.mst_en)
    begin
      pend = st.en & (st.swreq | st.auto | (hw_req & ~st.mask));
    end
  end

  mcdma_arb u_arb
  (
    .pend (pend),
    .hi   (st.prio),
    .any  (any),
    .gnt  (gnt)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [9:0]  cnt;
    logic [31:0] daddr;
    logic [10:0] bnext;
    cnt   = st.ctl[`MCDMA_CNT_MSB:`MCDMA_CNT_LSB];
    daddr = {st.base[31:7], st.use_alt, st.ch, st.idx, 2'b00};
    bnext = st.burst + 11'h1;
    n = st;
    n.mem.req = 1'b0;
    n.mem.we  = 1'b0;
    n.hw_ack  = 4'h0;
    // Flags clear before hardware sets so a same-cycle event survives
    if (reg_wr && reg_addr == `MCDMA_OFS_DONE)
    begin
      n.done = st.done & ~reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == `MCDMA_OFS_ERR)
    begin
      n.err = st.err & ~reg_wdata[3:0];
    end
    unique case (st.state)
      mcdma_pkg::S_IDLE:
      begin
        if (any)
        begin
          n.ch      = gnt;
          n.use_alt = st.alt[gnt];
          n.idx     = `MCDMA_IDX_SRC;
          n.state   = mcdma_pkg::S_FETCH;
        end
      end
      mcdma_pkg::S_FETCH:
      begin
        n.mem.req  = 1'b1;
        n.mem.size = `MCDMA_SIZE_WORD;
        n.mem.addr = daddr;
        n.state    = mcdma_pkg::S_FW;
      end
      mcdma_pkg::S_FW:
      begin
        n.state = mcdma_pkg::S_FCAP;
      end
      mcdma_pkg::S_FCAP:
      begin
        unique case (st.idx)
          `MCDMA_IDX_SRC: n.src = mem_rdata;
          `MCDMA_IDX_DST: n.dst = mem_rdata;
          default:        n.ctl = mem_rdata;
        endcase
        n.state = mcdma_pkg::S_IDLE;
        if (st.idx != `MCDMA_IDX_CTL)
        begin
          n.idx   = st.idx + 2'h1;
          n.state = mcdma_pkg::S_FETCH;
        end
        else if (mem_rdata[`MCDMA_MODE_MSB:`MCDMA_MODE_LSB] == `MCDMA_M_STOP)
        begin
          n.en[st.ch]    = 1'b0;
          n.swreq[st.ch] = 1'b0;
          n.auto[st.ch]  = 1'b0;
        end
        else if (mem_rdata[`MCDMA_SSIZE_MSB:`MCDMA_SSIZE_LSB] == `MCDMA_SIZE_RSVD ||
                 mem_rdata[`MCDMA_SSIZE_MSB:`MCDMA_SSIZE_LSB] !=
                 mem_rdata[`MCDMA_DSIZE_MSB:`MCDMA_DSIZE_LSB])
        begin
          // Reserved or unequal widths cannot be moved safely
          n.err[st.ch]   = 1'b1;
          n.en[st.ch]    = 1'b0;
          n.swreq[st.ch] = 1'b0;
          n.auto[st.ch]  = 1'b0;
        end
        else
        begin
          n.burst = 11'h0;
          n.mode  = mem_rdata[`MCDMA_MODE_MSB:`MCDMA_MODE_LSB];
          n.state = mcdma_pkg::S_RD;
        end
      end
      mcdma_pkg::S_RD:
      begin
        n.mem.req  = 1'b1;
        n.mem.size = st.ctl[`MCDMA_SSIZE_MSB:`MCDMA_SSIZE_LSB];
        n.mem.addr = elem_addr(st.src, cnt, st.ctl[`MCDMA_SINC_MSB:`MCDMA_SINC_LSB]);
        n.state    = mcdma_pkg::S_RW;
      end
      mcdma_pkg::S_RW:
      begin
        n.state = mcdma_pkg::S_RCAP;
      end
      mcdma_pkg::S_RCAP:
      begin
        n.data  = mem_rdata;
        n.state = mcdma_pkg::S_WR;
      end
      mcdma_pkg::S_WR:
      begin
        n.mem.req   = 1'b1;
        n.mem.we    = 1'b1;
        n.mem.size  = st.ctl[`MCDMA_DSIZE_MSB:`MCDMA_DSIZE_LSB];
        n.mem.addr  = elem_addr(st.dst, cnt, st.ctl[`MCDMA_DINC_MSB:`MCDMA_DINC_LSB]);
        n.mem.wdata = st.data;
        n.burst     = bnext;
        n.fin       = (cnt == 10'h0);
        if (cnt == 10'h0)
        begin
          n.ctl[`MCDMA_MODE_MSB:`MCDMA_MODE_LSB] = `MCDMA_M_STOP;
        end
        else
        begin
          n.ctl[`MCDMA_CNT_MSB:`MCDMA_CNT_LSB] = cnt - 10'h1;
        end
        // An exponent above 10 shifts to zero and never matches
        if (cnt == 10'h0 || bnext == (11'h1 << st.ctl[`MCDMA_R_MSB:`MCDMA_R_LSB]))
        begin
          n.state = mcdma_pkg::S_WB;
        end
        else
        begin
          n.state = mcdma_pkg::S_RD;
        end
      end
      mcdma_pkg::S_WB:
      begin
        n.mem.req   = 1'b1;
        n.mem.we    = 1'b1;
        n.mem.size  = `MCDMA_SIZE_WORD;
        n.mem.addr  = daddr;
        n.mem.wdata = st.ctl;
        n.hw_ack[st.ch] = 1'b1;
        n.swreq[st.ch]  = 1'b0;
        // Auto and memory scatter-gather resume without a new request
        n.auto[st.ch] = (st.mode == `MCDMA_M_AUTO && !st.fin) ||
                        st.mode == `MCDMA_M_MSG_PRI || st.mode == `MCDMA_M_MSG_ALT;
        if (st.mode == `MCDMA_M_MSG_PRI || st.mode == `MCDMA_M_PSG_PRI)
        begin
          n.alt[st.ch] = 1'b1;
        end
        if (st.fin)
        begin
          unique case (st.mode)
            `MCDMA_M_BASIC, `MCDMA_M_AUTO: n.done[st.ch] = 1'b1;
            `MCDMA_M_PING:
            begin
              n.done[st.ch] = 1'b1;
              n.alt[st.ch]  = ~st.alt[st.ch];
            end
            `MCDMA_M_MSG_ALT, `MCDMA_M_PSG_ALT: n.alt[st.ch] = 1'b0;
            default: n.alt[st.ch] = 1'b1;
          endcase
        end
        n.state = mcdma_pkg::S_IDLE;
      end
    endcase
    // Software set and clear writes land after the engine's updates
    if (reg_wr)
    begin
      unique case (reg_addr)
        `MCDMA_OFS_CFG:    n.mst_en = reg_wdata[0];
        `MCDMA_OFS_BASE:   n.base = {reg_wdata[31:7], `MCDMA_BASE_ZERO};
        `MCDMA_OFS_SWREQ:  n.swreq = n.swreq | reg_wdata[3:0];
        `MCDMA_OFS_PRSET:  n.prio = n.prio | reg_wdata[3:0];
        `MCDMA_OFS_PRCLR:  n.prio = n.prio & ~reg_wdata[3:0];
        `MCDMA_OFS_RMSET:  n.mask = n.mask | reg_wdata[3:0];
        `MCDMA_OFS_RMCLR:  n.mask = n.mask & ~reg_wdata[3:0];
        `MCDMA_OFS_ENSET:  n.en = n.en | reg_wdata[3:0];
        `MCDMA_OFS_ENCLR:  n.en = n.en & ~reg_wdata[3:0];
        `MCDMA_OFS_PASET:  n.alt = n.alt | reg_wdata[3:0];
        `MCDMA_OFS_PACLR:  n.alt = n.alt & ~reg_wdata[3:0];
        `MCDMA_OFS_DIESET: n.done_ie = n.done_ie | reg_wdata[3:0];
        `MCDMA_OFS_DIECLR: n.done_ie = n.done_ie & ~reg_wdata[3:0];
        `MCDMA_OFS_EIESET: n.err_ie = n.err_ie | reg_wdata[3:0];
        `MCDMA_OFS_EIECLR: n.err_ie = n.err_ie & ~reg_wdata[3:0];
        default:           n.mst_en = n.mst_en;
      endcase
    end
    n.rdata = 32'h0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `MCDMA_OFS_CFG:    n.rdata = {31'h0, st.mst_en};
        `MCDMA_OFS_BASE:   n.rdata = st.base;
        `MCDMA_OFS_ALT:    n.rdata = st.base + `MCDMA_ALT_OFS;
        `MCDMA_OFS_SWREQ:  n.rdata = {28'h0, st.swreq | st.auto};
        `MCDMA_OFS_PRSET, `MCDMA_OFS_PRCLR:   n.rdata = {28'h0, st.prio};
        `MCDMA_OFS_RMSET, `MCDMA_OFS_RMCLR:   n.rdata = {28'h0, st.mask};
        `MCDMA_OFS_ENSET, `MCDMA_OFS_ENCLR:   n.rdata = {28'h0, st.en};
        `MCDMA_OFS_PASET, `MCDMA_OFS_PACLR:   n.rdata = {28'h0, st.alt};
        `MCDMA_OFS_DONE:   n.rdata = {28'h0, st.done};
        `MCDMA_OFS_ERR:    n.rdata = {28'h0, st.err};
        `MCDMA_OFS_DIESET, `MCDMA_OFS_DIECLR: n.rdata = {28'h0, st.done_ie};
        `MCDMA_OFS_EIESET, `MCDMA_OFS_EIECLR: n.rdata = {28'h0, st.err_ie};
        default:           n.rdata = 32'h0;
      endcase
    end
    n.irq = ((n.done & n.done_ie) | (n.err & n.err_ie)) != 4'h0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= n;
    end
  end

  assign reg_rdata = st.rdata;
  assign hw_ack    = st.hw_ack;
  assign mem_out   = st.mem;
  assign dma_irq   = st.irq;

  // ==========================================================
  // Checks
  AST_BASE_ALIGN: assert property (@(posedge clk) disable iff (!nrst)
    st.base[6:0] == 7'h00) else $error("descriptor base not aligned");

  AST_ALT_PTR: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == `MCDMA_OFS_ALT |=> reg_rdata == $past(st.base) + 32'h40)
    else $error("alternate pointer wrong");

  AST_DESC_ADDR: assert property (@(posedge clk) disable iff (!nrst)
    st.state == mcdma_pkg::S_FW |-> st.mem.req && !st.mem.we &&
    st.mem.addr == st.base + {25'h0, st.use_alt, st.ch, st.idx, 2'b00})
    else $error("descriptor fetch address wrong");

  AST_PRIO_HIGH: assert property (@(posedge clk) disable iff (!nrst)
    any && (pend & st.prio) != 4'h0 |-> st.prio[gnt])
    else $error("low priority channel beat a high one");

  AST_PRIO_LOW: assert property (@(posedge clk) disable iff (!nrst)
    any |-> (pend & ((4'h1 << gnt) - 4'h1) & (st.prio[gnt] ? st.prio : ~st.prio)) == 4'h0)
    else $error("higher channel number beat a lower one");

  AST_MASKED: assert property (@(posedge clk) disable iff (!nrst)
    any && !(st.swreq[gnt] || st.auto[gnt]) |-> hw_req[gnt] && !st.mask[gnt])
    else $error("masked hardware request was served");

  AST_ENABLED: assert property (@(posedge clk) disable iff (!nrst)
    st.state == mcdma_pkg::S_IDLE && any |=> st.state == mcdma_pkg::S_FETCH &&
    $past(st.en[gnt]) && $past(st.mst_en))
    else $error("disabled channel started");

  AST_DONE_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    st.state == mcdma_pkg::S_WB && st.fin && st.mode == `MCDMA_M_BASIC
    |=> st.done[$past(st.ch)] && st.state == mcdma_pkg::S_IDLE)
    else $error("completion flag not raised");

  AST_STOP_MODE: assert property (@(posedge clk) disable iff (!nrst)
    st.state == mcdma_pkg::S_FCAP && st.idx == 2'h2 && mem_rdata[2:0] == 3'h0
    |=> st.state == mcdma_pkg::S_IDLE ##1 !st.mem.we)
    else $error("stop mode moved data");

  AST_SET_REG: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == `MCDMA_OFS_ENSET |=> (st.en & $past(reg_wdata[3:0])) ==
    $past(reg_wdata[3:0]))
    else $error("set register did not set");

endmodule

// ---- multi_channel_dma_controller_bench.sv ----
// Self-checking bench of the four-channel DMA controller.
// Drives the register port and request lines; RAM is mcdma_mem_model.
`timescale 1ns/1ps
`include "mcdma_params.svh"

module multi_channel_dma_controller_bench;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } mcdma_row_t;

  logic                  clk;
  logic                  nrst;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [31:0]           reg_rdata;
  logic [3:0]            hw_req;
  logic [3:0]            preq;
  logic [3:0]            hw_ack;
  mcdma_pkg::mcdma_mem_t mem_out;
  logic [31:0]           mem_rdata;
  logic                  dma_irq;
  int                    fail_count;
  int                    checks_done;
  logic [31:0]           v;
  logic [1:0]            order [$];
  mcdma_row_t            rows [11];

  mcdma_top DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_req(hw_req),
    .hw_ack(hw_ack), .mem_out(mem_out), .mem_rdata(mem_rdata), .dma_irq(dma_irq));
  mcdma_mem_model mem (.clk(clk), .mem_in(mem_out), .rdata(mem_rdata));

  // Level source drops while the ack stands, else the idle engine serves it again
  assign hw_req = preq & ~hw_ack;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // First destination write of each channel, in service order
  always @(posedge clk)
    if (mem_out.req && mem_out.we && mem_out.addr[11:8] == 4'h8)
      if (order.size() == 0 || order[$] != mem_out.addr[7:6])
        order.push_back(mem_out.addr[7:6]);

  // ==========================================================
  // Tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    rd(a, v);
    chk(nm, ex, v);
  endtask

  task automatic desc(input int ch, input int alt, input logic [31:0] s, d, c);
    int i;
    i = (32'h180 + alt * 32'h40 + ch * 16) >> 2;
    mem.ram[i]     = s;
    mem.ram[i + 1] = d;
    mem.ram[i + 2] = c;
  endtask

  // Steps fixed at +4; only width, exponent, count and mode vary
  function automatic logic [31:0] ctl(input logic [1:0] sz, input logic [3:0] r,
                                      input logic [9:0] n, input logic [2:0] m);
    return {2'h2, sz, 2'h2, sz, 6'h00, r, n, 1'b0, m};
  endfunction

  task automatic wait_flag(input logic [7:0] a, input logic [3:0] m);
    int k;
    for (k = 0; k < 100; k++)
    begin
      rd(a, v);
      if ((v[3:0] & m) == m)
        break;
    end
    if (k == 100)
    begin
      chk("flag wait", {28'h0, m}, v);
      test_done();
    end
  endtask

  task automatic wait_ack(input int ch);
    int k;
    for (k = 0; k < 200 && hw_ack[ch] !== 1'b1; k++)
      @(posedge clk) #1;
    if (k == 200)
    begin
      chk("ack wait", 32'h1, 32'h0);
      test_done();
    end
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    preq = 4'h0;
    fail_count = 0;
    checks_done = 0;
    rows = '{'{`MCDMA_OFS_BASE, 32'h180, `MCDMA_OFS_ALT, 32'h1C0},
             '{`MCDMA_OFS_ALT, 32'hFFFF_FFFF, `MCDMA_OFS_ALT, 32'h1C0},
             '{`MCDMA_OFS_BASE, 32'h1FF, `MCDMA_OFS_BASE, 32'h180},
             '{`MCDMA_OFS_PRSET, 32'h3, `MCDMA_OFS_PRCLR, 32'h3},
             '{`MCDMA_OFS_PRCLR, 32'h1, `MCDMA_OFS_PRSET, 32'h2},
             '{`MCDMA_OFS_RMSET, 32'hF, `MCDMA_OFS_RMSET, 32'hF},
             '{`MCDMA_OFS_RMCLR, 32'h7, `MCDMA_OFS_RMCLR, 32'h8},
             '{`MCDMA_OFS_DIESET, 32'h3, `MCDMA_OFS_DIECLR, 32'h3},
             '{`MCDMA_OFS_DIECLR, 32'h2, `MCDMA_OFS_EIESET, 32'h0},
             '{`MCDMA_OFS_EIESET, 32'h1, `MCDMA_OFS_DIESET, 32'h1},
             '{8'h80, 32'hFFFF_FFFF, 8'h80, 32'h0}};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rchk(`MCDMA_OFS_BASE, 32'h0, "base after reset");
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, v);
      chk("register row", rows[i].ex, v);
    end
    // Descriptors ready before master enable
    mem.ram[10'h100] = 32'h1234_565A;
    mem.ram[10'h200] = 32'hFFFF_FFFF;
    desc(0, 0, 32'h400, 32'h800, ctl(2'h0, 4'h0, 10'h0, `MCDMA_M_BASIC));
    wr(`MCDMA_OFS_CFG, 32'h1);
    wr(`MCDMA_OFS_ENSET, 32'h1);
    wr(`MCDMA_OFS_SWREQ, 32'h1);
    wait_flag(`MCDMA_OFS_DONE, 4'h1);
    chk("byte element", 32'hFFFF_FF5A, mem.ram[10'h200]);
    chk("mode written back", 32'h0, {29'h0, mem.ram[10'h62][2:0]});
    chk("irq raised", 32'h1, {31'h0, dma_irq});
    wr(`MCDMA_OFS_DONE, 32'h1);
    rchk(`MCDMA_OFS_DONE, 32'h0, "done cleared");
    chk("irq dropped", 32'h0, {31'h0, dma_irq});
    // Three channels at once: ch1 high, then ch0, then ch2
    mem.ram[10'h101] = 32'hC1C1_0001;
    mem.ram[10'h102] = 32'hC2C2_0002;
    mem.ram[10'h103] = 32'hC3C3_0003;
    for (int c = 0; c < 4; c++)
      desc(c, 0, 32'h400 + c * 4, 32'h800 + c * 32'h40, ctl(2'h2, 4'h0, 10'h0, `MCDMA_M_BASIC));
    order.delete();
    wr(`MCDMA_OFS_ENSET, 32'h7);
    wr(`MCDMA_OFS_SWREQ, 32'h7);
    wait_flag(`MCDMA_OFS_DONE, 4'h7);
    chk("service order", 32'h12, {26'h0, order[0], order[1], order[2]});
    chk("word element", 32'hC1C1_0001, mem.ram[10'h210]);
    wr(`MCDMA_OFS_DONE, 32'h7);
    // Disabled channel and masked hardware request both stay idle
    desc(2, 0, 32'h408, 32'h880, ctl(2'h2, 4'h0, 10'h0, `MCDMA_M_BASIC));
    wr(`MCDMA_OFS_ENCLR, 32'h4);
    wr(`MCDMA_OFS_ENSET, 32'h8);
    @(posedge clk) preq <= 4'h8;
    wr(`MCDMA_OFS_SWREQ, 32'h4);
    repeat (40) @(posedge clk);
    rchk(`MCDMA_OFS_DONE, 32'h0, "idle while blocked");
    wr(`MCDMA_OFS_ENSET, 32'h4);
    wait_flag(`MCDMA_OFS_DONE, 4'h4);
    wr(`MCDMA_OFS_RMCLR, 32'h8);
    wait_ack(3);
    @(posedge clk) preq <= 4'h0;
    wait_flag(`MCDMA_OFS_DONE, 4'h8);
    chk("hw request copy", 32'hC3C3_0003, mem.ram[10'h230]);
    wr(`MCDMA_OFS_DONE, 32'hF);
    // Four words, pause after two: basic waits for a new request, auto goes on
    for (int m = 0; m < 2; m++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        mem.ram[10'h110 + k] = 32'hA000_0000 + k;
        mem.ram[10'h240 + k] = 32'h0;
      end
      desc(0, 0, 32'h44C, 32'h90C,
           ctl(2'h2, 4'h1, 10'h3, (m == 0) ? `MCDMA_M_BASIC : `MCDMA_M_AUTO));
      wr(`MCDMA_OFS_SWREQ, 32'h1);
      if (m == 0)
      begin
        wait_ack(0);
        repeat (4) @(posedge clk);
        chk("paused", 32'h0, mem.ram[10'h242]);
        chk("count left", 32'h1, {22'h0, mem.ram[10'h62][13:4]});
        rchk(`MCDMA_OFS_DONE, 32'h0, "no done at pause");
        wr(`MCDMA_OFS_SWREQ, 32'h1);
      end
      wait_flag(`MCDMA_OFS_DONE, 4'h1);
      for (int k = 0; k < 4; k++)
        chk("burst word", 32'hA000_0000 + k, mem.ram[10'h240 + k]);
      wr(`MCDMA_OFS_DONE, 32'h1);
    end
    // Alternate select: primary of ch1 holds stop, so only alternate can finish
    wr(`MCDMA_OFS_PASET, 32'h2);
    desc(1, 1, 32'h404, 32'h850, ctl(2'h2, 4'h0, 10'h0, `MCDMA_M_BASIC));
    wr(`MCDMA_OFS_SWREQ, 32'h2);
    wait_flag(`MCDMA_OFS_DONE, 4'h2);
    chk("alternate copy", 32'hC1C1_0001, mem.ram[10'h214]);
    wr(`MCDMA_OFS_DONE, 32'h2);
    // Reserved width raises error; stop mode idles the channel silently
    desc(0, 0, 32'h400, 32'h800, ctl(2'h3, 4'h0, 10'h0, `MCDMA_M_BASIC));
    wr(`MCDMA_OFS_SWREQ, 32'h1);
    wait_flag(`MCDMA_OFS_ERR, 4'h1);
    chk("irq on error", 32'h1, {31'h0, dma_irq});
    wr(`MCDMA_OFS_ERR, 32'h1);
    rchk(`MCDMA_OFS_ERR, 32'h0, "error cleared");
    wr(`MCDMA_OFS_PACLR, 32'h2);
    wr(`MCDMA_OFS_SWREQ, 32'h2);
    repeat (30) @(posedge clk);
    rchk(`MCDMA_OFS_ENSET, 32'hC, "enables after stop");
    rchk(`MCDMA_OFS_DONE, 32'h0, "no flag on stop");
    // Ping-pong finish raises done and swaps the channel to its alternate
    desc(2, 0, 32'h408, 32'h880, ctl(2'h2, 4'h0, 10'h0, `MCDMA_M_PING));
    wr(`MCDMA_OFS_SWREQ, 32'h4);
    wait_flag(`MCDMA_OFS_DONE, 4'h4);
    rchk(`MCDMA_OFS_PASET, 32'h4, "ping-pong swap");
    // Reset in mid-run clears every register again
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(`MCDMA_OFS_BASE, 32'h0, "base after mid reset");
    rchk(`MCDMA_OFS_DONE, 32'h0, "done after mid reset");
    rchk(`MCDMA_OFS_PASET, 32'h0, "select after mid reset");
    rchk(`MCDMA_OFS_CFG, 32'h0, "master after mid reset");
    test_done();
  end
endmodule
